// ==== rtl/dasr_params.svh ====
// Constants for the dual converter serial readout block
`ifndef DASR_PARAMS_SVH
`define DASR_PARAMS_SVH
`define DASR_FRAME_CLKS   6'd32
`define DASR_SAMPLE_EDGE  6'd4
`define DASR_WORD_BITS    5'd12
`define DASR_A_FIRST_BIT  6'd4
`define DASR_B_FIRST_BIT  6'd16
`define DASR_B_LAST_BIT   6'd27
`define DASR_RESET_WORD   12'h000
`endif

// ==== rtl/dasr_pkg.sv ====
// Types for the dual converter serial readout block
package dasr_pkg;
    typedef enum logic [1:0] {
        DASR_POWER_DOWN,
        DASR_FRAME,
        DASR_DONE
    } dasr_state_type;
endpackage

// ==== rtl/dasr_pin_sync.sv ====
// Two flip-flop synchroniser with edge outputs
`timescale 1ns/1ns
`default_nettype none
module dasr_pin_sync (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    input  wire logic rst_level_in,
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } dasr_sync_type;

    dasr_sync_type s_r;
    dasr_sync_type s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = pin_in;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            s_r <= {rst_level_in, rst_level_in, rst_level_in};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level_out = s_r.sync;
    assign rise_out  = s_r.sync & ~s_r.prev;
    assign fall_out  = ~s_r.sync & s_r.prev;
endmodule
`default_nettype wire

// ==== rtl/dasr_readout.sv ====
// Serial frame control and result readout of a dual simultaneous-sampling converter
`timescale 1ns/1ns
`default_nettype none
`include "dasr_params.svh"
module dasr_readout (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        cs_n_in,
    input  wire logic        sclk_in,
    input  wire logic [11:0] chan_a_in,
    input  wire logic [11:0] chan_b_in,
    output logic             sdo_out,
    output logic             sdo_oe_out,
    output logic             sample_out,
    output logic             powered_down_out
);
    typedef struct packed {
        dasr_pkg::dasr_state_type state;
        logic [5:0]               falls;
        logic [11:0]              word_a;
        logic [11:0]              word_b;
        logic                     sdo;
        logic                     oe;
        logic                     sample;
    } dasr_core_type;

    dasr_core_type r_r;
    dasr_core_type r_nxt;

    // -----------------------------------------------------------------
    // Synchronised pin views
    // -----------------------------------------------------------------
    // Both pins come from the host's domain. Each passes two flip-flops
    // before the frame logic reads it. The edge strobes last one core
    // cycle, so every serial clock fall counts exactly once.
    logic cs_level;
    logic cs_fall;
    logic sclk_level;
    logic sclk_fall;

    dasr_pin_sync u_cs_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .pin_in      (cs_n_in),
        .rst_level_in(1'b1),
        .level_out   (cs_level),
        .rise_out    (),
        .fall_out    (cs_fall)
    );

    dasr_pin_sync u_sclk_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .pin_in      (sclk_in),
        .rst_level_in(1'b1),
        .level_out   (sclk_level),
        .rise_out    (),
        .fall_out    (sclk_fall)
    );

    // -----------------------------------------------------------------
    // Fall index decoding
    // -----------------------------------------------------------------
    // True on the fall at which both channels are captured together
    function automatic logic is_sample_fall(input logic [5:0] idx);
        is_sample_fall = (idx == `DASR_SAMPLE_EDGE);
    endfunction

    // True on the fall that closes the frame
    function automatic logic is_last_fall(input logic [5:0] idx);
        is_last_fall = (idx == `DASR_FRAME_CLKS);
    endfunction

    // -----------------------------------------------------------------
    // Bit selection for a falling edge index
    // -----------------------------------------------------------------
    // Falls before the A word and after the B word carry zero pad bits.
    // The words passed in must be those of the current frame, so the
    // caller hands over the words as they stand after a capture.
    function automatic logic bit_for_fall(input logic [5:0]  idx,
                                          input logic [11:0] wa,
                                          input logic [11:0] wb);
        logic [5:0] off;
        off = 6'h00;
        bit_for_fall = 1'b0;
        if (idx >= `DASR_A_FIRST_BIT && idx < `DASR_B_FIRST_BIT) begin
            off = idx - `DASR_A_FIRST_BIT;
            bit_for_fall = wa[4'hB - off[3:0]];
        end else if (idx >= `DASR_B_FIRST_BIT && idx <= `DASR_B_LAST_BIT) begin
            off = idx - `DASR_B_FIRST_BIT;
            bit_for_fall = wb[4'hB - off[3:0]];
        end
    endfunction

    // -----------------------------------------------------------------
    // Frame sequencing
    // -----------------------------------------------------------------
    always_comb begin
        r_nxt        = r_r;
        r_nxt.sample = 1'b0;
        case (r_r.state)
            dasr_pkg::DASR_POWER_DOWN: begin
                r_nxt.oe  = 1'b0;
                r_nxt.sdo = 1'b0;
                r_nxt.falls = 6'h00;
                if (cs_fall) begin
                    r_nxt.state = dasr_pkg::DASR_FRAME;
                    r_nxt.oe    = 1'b1;
                end
            end
            // Counting falls; data only ever moves on a synchronised fall
            dasr_pkg::DASR_FRAME: begin
                if (sclk_fall) begin
                    r_nxt.falls = r_r.falls + 6'h01;
                    // Both channels are taken in the same core cycle
                    if (is_sample_fall(r_nxt.falls)) begin
                        r_nxt.word_a = chan_a_in;
                        r_nxt.word_b = chan_b_in;
                        r_nxt.sample = 1'b1;
                    end
                    // The freshly captured words feed the MSB at once
                    r_nxt.sdo = bit_for_fall(r_nxt.falls, r_nxt.word_a, r_nxt.word_b);
                    // Further falls wait for a new select cycle
                    if (is_last_fall(r_nxt.falls)) begin
                        r_nxt.state = dasr_pkg::DASR_DONE;
                        r_nxt.sdo   = 1'b0;
                    end
                end
            end
            // Frame complete: keep driving zero until select rises
            dasr_pkg::DASR_DONE: begin
                r_nxt.sdo = 1'b0;
            end
            default: begin
                r_nxt.state = dasr_pkg::DASR_POWER_DOWN;
            end
        endcase
        // Select high overrides every state: abort and power down
        if (cs_level) begin
            r_nxt.state  = dasr_pkg::DASR_POWER_DOWN;
            r_nxt.oe     = 1'b0;
            r_nxt.sdo    = 1'b0;
            r_nxt.falls  = 6'h00;
            r_nxt.sample = 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            r_r.state  <= dasr_pkg::DASR_POWER_DOWN;
            r_r.falls  <= 6'h00;
            r_r.word_a <= `DASR_RESET_WORD;
            r_r.word_b <= `DASR_RESET_WORD;
            r_r.sdo    <= 1'b0;
            r_r.oe     <= 1'b0;
            r_r.sample <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    // All come from the state register; powered_down_out is decoded from its state field
    assign sdo_out          = r_r.sdo;
    assign sdo_oe_out       = r_r.oe;
    assign sample_out       = r_r.sample;
    assign powered_down_out = (r_r.state == dasr_pkg::DASR_POWER_DOWN);
endmodule
`default_nettype wire

// ==== testbench/dasr_readout_monitor.sv ====
// Port checker for the readout block
`timescale 1ns/1ns
`default_nettype none
module dasr_readout_monitor (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic sdo_out,
    input wire logic sdo_oe_out,
    input wire logic sample_out,
    input wire logic powered_down_out
);
    logic [9:0] gap_r;
    // Cycles since the last capture, saturating
    always_ff @(posedge core_clk_in) begin
        gap_r <= rst_in ? 10'h3FF : sample_out ? 10'h000 : gap_r + {9'h000, ~&gap_r};
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    oe_pd_a: assert property (sdo_oe_out |-> !powered_down_out) else $error("oe in pd");
    pd_quiet_a: assert property (powered_down_out |-> !sample_out) else $error("pd sample");
    oe_rise_a: assert property ($rose(sdo_oe_out) |-> $past(!cs_n_in, 2)) else $error("oe on");
    oe_fall_a: assert property ($fell(sdo_oe_out) |-> $past(cs_n_in, 2)) else $error("oe off");
    sdo_edge_a: assert property (sdo_oe_out && $past(sdo_oe_out) && $changed(sdo_out)
        |-> $past(!sclk_in, 2)) else $error("sdo edge");
    smp_fall_a: assert property (sample_out |-> !sclk_in && $past(!sclk_in, 2))
        else $error("sample edge");
    smp_gap_a: assert property (sample_out |-> gap_r >= 10'h0C0) else $error("rate");
    smp_once_a: assert property (sample_out |=> !sample_out [*2]) else $error("pulse");
endmodule
bind dasr_readout dasr_readout_monitor mon (.*);
`default_nettype wire

// ==== testbench/dasr_host_model.sv ====
// Host model: drives select and serial clock, shifts in data at rising edges
`timescale 1ns/1ns
`default_nettype none
module dasr_host_model (
    input  wire logic   core_clk_in,
    input  wire logic   sdo_in,
    output var logic        cs_n_out,
    output var logic        sclk_out,
    output var logic [31:0] word_out
);
    initial {cs_n_out, sclk_out, word_out} = {2'h3, 32'h0};
    // Clock idles high; select is low before the first rising edge
    task automatic frame(input int n, input logic sel);
        cs_n_out <= ~sel;
        repeat (8) @(posedge core_clk_in);
        for (int i = 0; i < n; i++) begin
            sclk_out <= 1'h0;
            repeat (8) @(posedge core_clk_in);
            word_out <= {word_out[30:0], sdo_in};
            sclk_out <= 1'h1;
            repeat (8) @(posedge core_clk_in);
        end
        cs_n_out <= 1'h1;
        repeat (32) @(posedge core_clk_in);
    endtask
endmodule
`default_nettype wire

// ==== testbench/dasr_readout_tb_top.sv ====
// Testbench for the readout block
`timescale 1ns/1ns
`default_nettype none
module dasr_readout_tb_top;
    logic clk = 1'h0, rst = 1'h1;
    logic [11:0] a = 12'h000, b = 12'h000;
    logic cs_n, sclk, sdo, oe, smp, pd;
    logic [31:0] word;
    int error_cnt = 0, check_count = 0, nsmp = 0, cyc = 0;
    always #2 clk = ~clk;
    dasr_readout dut (.core_clk_in(clk), .rst_in(rst), .cs_n_in(cs_n), .sclk_in(sclk),
        .chan_a_in(a), .chan_b_in(b), .sdo_out(sdo), .sdo_oe_out(oe),
        .sample_out(smp), .powered_down_out(pd));
    dasr_host_model host (.core_clk_in(clk), .sdo_in(sdo), .cs_n_out(cs_n),
        .sclk_out(sclk), .word_out(word));
    always @(posedge clk) begin
        nsmp <= nsmp + int'(smp === 1'h1);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic t_idle();
        int s0 = nsmp;
        host.frame(32, 1'h0);
        chk("n smp", 32'(s0), 32'(nsmp));
        chk("pd", 32'h1, {31'h0, pd});
        $display("idle test done");
    endtask
    task automatic t_abort();
        int s0 = nsmp;
        a <= 12'h800;
        host.frame(3, 1'h1);
        chk("n smp", 32'(s0), 32'(nsmp));
        host.frame(10, 1'h1);
        chk("n smp", 32'(s0 + 1), 32'(nsmp));
        chk("oe", 32'h0, {31'h0, oe});
        $display("abort test done");
    endtask
    task automatic t_frames();
        int s0;
        for (int k = 0; k < 2; k++) begin
            s0 = nsmp;
            a <= k ? 12'h5C3 : 12'hA3C;
            b <= k ? 12'h812 : 12'h7ED;
            host.frame(32, 1'h1);
            chk("word", {3'h0, a, b, 5'h00}, word);
            chk("n smp", 32'(s0 + 1), 32'(nsmp));
        end
        $display("frame test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        t_idle();
        t_abort();
        t_frames();
        tally_and_finish();
    end
endmodule
`default_nettype wire
